// File: bench/dmd_far_side.sv
`timescale 1ns/1ps
module dmd_far_side (
    // clock
    input wire logic sys_clk,
    // half periods, in sys_clk cycles
    input wire logic [9:0] in_half,
    input wire logic [9:0] sec_half,
    input wire logic [9:0] mref_half,
    input wire logic [9:0] sref_half,
    // generated signals
    output logic prescaled_input_signal,
    output logic sec_mixer_signal,
    output logic main_ref_signal,
    output logic sec_ref_signal
);
    logic [3:0][9:0] half;
    logic [3:0][9:0] cnt = '0;
    logic [3:0] sig = 4'h0;
    assign half = {sref_half, mref_half, sec_half, in_half};
    // free running, like the oscillators behind the mixers
    always @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (cnt[i] + 10'h001 >= half[i]) begin
                cnt[i] <= 10'h000;
                sig[i] <= ~sig[i];
            end else begin
                cnt[i] <= cnt[i] + 10'h001;
            end
        end
    end
    assign prescaled_input_signal = sig[0];
    assign sec_mixer_signal = sig[1];
    assign main_ref_signal = sig[2];
    assign sec_ref_signal = sig[3];
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [1:0] t;
        logic [3:0] u;
        logic [3:0] h;
        logic [3:0] d;
        logic [3:0] o;
        logic [8:0] ratio;
        logic [9:0] rank;
    } dmd_row_s;
    dmd_row_s rows [7] = '{
        '{2'h0, 4'h2, 4'h0, 4'h0, 4'h0, 9'h028, 10'h1F4},
        '{2'h0, 4'h2, 4'h8, 4'h0, 4'h0, 9'h030, 10'h1F4},
        '{2'h0, 4'h3, 4'h6, 4'h0, 4'h0, 9'h038, 10'h1F4},
        '{2'h0, 4'h2, 4'h1, 4'h9, 4'h9, 9'h028, 10'h2BB},
        '{2'h2, 4'h9, 4'h9, 4'h9, 4'h9, 9'h13E, 10'h2BB},
        '{2'h1, 4'h5, 4'h0, 4'h5, 4'h7, 9'h0AA, 10'h22D},
        '{2'h1, 4'h6, 4'h3, 4'h5, 4'h0, 9'h0B6, 10'h28A}};
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    dmd_row_s cur = '0;
    logic [9:0] mref_half = 10'h050;
    logic [9:0] sref_half = 10'h1F4;
    logic in_s, sec_s, mref_s, sref_s, div_out, mod12, sec_out, ml, sl;
    logic [7:0] msc, ssc;
    logic in_d = 1'b0;
    logic sec_d = 1'b0;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int mcnt = 0, mlast = 0, mhi = 0, mlast_hi = 0, mpulses = 0, scnt = 0, slast = 0, spulses = 0;
    always #25 sys_clk = ~sys_clk;
    dmd_far_side far (.sys_clk(sys_clk), .in_half(10'h002), .sec_half(10'h001), .mref_half(mref_half),
        .sref_half(sref_half), .prescaled_input_signal(in_s), .sec_mixer_signal(sec_s),
        .main_ref_signal(mref_s), .sec_ref_signal(sref_s));
    dmd_divider #(.WIN_LEN(3)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
        .set_mhz_tens(cur.t), .set_mhz_units(cur.u), .set_khz100(cur.h), .set_khz10(cur.d),
        .set_khz1(cur.o), .prescaled_input_signal(in_s), .sec_mixer_signal(sec_s),
        .main_ref_signal(mref_s), .sec_ref_signal(sref_s), .divided_output_signal(div_out),
        .mod12_sel(mod12), .sec_divided_output(sec_out), .main_search_code(msc),
        .sec_search_code(ssc), .main_locked(ml), .sec_locked(sl));
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wait_pulses(input int n);
        int m;
        int s;
        m = mpulses + n;
        s = spulses + n;
        while (mpulses < m || spulses < s)
            @(posedge sys_clk);
    endtask
    // edges counted between end pulses; a constant pulse lag cancels out
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 80000) begin
            failures++;
            end_of_test();
        end
    end
    always @(posedge sys_clk) begin
        if (div_out === 1'b1) begin
            mlast = mcnt;
            mlast_hi = mhi;
            mcnt = 0;
            mhi = 0;
            mpulses++;
        end
        if (in_s && !in_d)
            mcnt++;
        if (mod12 === 1'b1)
            mhi++;
        if (sec_out === 1'b1) begin
            slast = scnt;
            scnt = 0;
            spulses++;
        end
        if (sec_s && !sec_d)
            scnt++;
        in_d = in_s;
        sec_d = sec_s;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check("reset_code", msc, 8'h80);
        foreach (rows[i]) begin
            cur <= rows[i];
            // the second period is the first loaded with the new setting
            wait_pulses(3);
            check("ratio", mlast, rows[i].ratio);
            check("sec_rank", slast, rows[i].rank);
            check("mod12_used", mlast_hi != 0, rows[i].h > 4'h1);
        end
        $display("test rows done");
        // reset mid-run with a slow main and a fast secondary reference
        cur <= rows[1];
        mref_half <= 10'h140;
        sref_half <= 10'h014;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b0;
        #1;
        check("rst_main_code", msc, 8'h80);
        check("rst_pulse", div_out, 1'b0);
        check("rst_mod12", mod12, 1'b0);
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("mod12_start", mod12, 1'b1);
        for (int n = 0; n < 400 && ssc === 8'h80; n++)
            @(posedge sys_clk);
        check("sec_code_up", ssc, 8'h81);
        for (int n = 0; n < 3000 && msc === 8'h80; n++)
            @(posedge sys_clk);
        check("main_code_down", msc, 8'h7F);
        wait_pulses(2);
        check("ratio_all_twelve", mlast, 9'h030);
        $display("test reset and search done");
        mref_half <= 10'h060;
        sref_half <= 10'h1F4;
        for (int n = 0; n < 12000 && !(ml === 1'b1 && sl === 1'b1); n++)
            @(posedge sys_clk);
        check("main_locked", ml, 1'b1);
        check("sec_locked", sl, 1'b1);
        $display("test lock done");
        end_of_test();
    end
endmodule

// File: rtl/dmd_divider.sv
`timescale 1ns/1ps
module dmd_divider #(
    parameter int WIN_LEN = 8
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // front-panel setting digits, bcd
    input wire logic [1:0] set_mhz_tens,
    input wire logic [3:0] set_mhz_units,
    input wire logic [3:0] set_khz100,
    input wire logic [3:0] set_khz10,
    input wire logic [3:0] set_khz1,
    // divided-down signals and references
    input wire logic prescaled_input_signal,
    input wire logic sec_mixer_signal,
    input wire logic main_ref_signal,
    input wire logic sec_ref_signal,
    // outputs
    output logic divided_output_signal,
    output logic mod12_sel,
    output logic sec_divided_output,
    output logic [7:0] main_search_code,
    output logic [7:0] sec_search_code,
    output logic main_locked,
    output logic sec_locked
);
    typedef struct packed {
        logic armed;
        logic pin_d;
        logic mix_d;
        logic [1:0] ref_d;
        logic [3:0] pre_cnt;
        logic mod12;
        logic [2:0] twelve_left;
        logic [4:0] rank_left;
        logic div_out;
        logic sec_out;
        logic [1:0][7:0] code;
        logic [1:0][3:0] win_cnt;
        logic [1:0][4:0] hit_cnt;
        logic [1:0] locked;
    } dmd_state_s;

    localparam logic [3:0] WIN_L = 4'(WIN_LEN);
    localparam logic [4:0] WIN_W = 5'(WIN_LEN);

    if (WIN_LEN < 3 || WIN_LEN > 14) begin : g_bad_win
        $error("dmd_divider: WIN_LEN must be 3..14");
    end

    logic [1:0] rst_sync;
    logic rst_n;
    dmd_state_s st_reg;
    dmd_state_s st_next;
    logic [4:0] rank_set;
    logic [2:0] twelve_set;
    logic [9:0] sec_rank;
    logic step;
    logic pre_done;
    logic sec_term;
    logic [1:0] ev_out;
    logic [1:0] ev_ref;
    logic [3:0] pre_mod;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // rank is whole MHz plus two; twelves are half the 100 kHz digit
    assign rank_set = 5'(set_mhz_tens) * dmd_pkg::MHZ_TENS_WEIGHT + 5'(set_mhz_units)
        + dmd_pkg::RANK_OFFSET;
    assign twelve_set = set_khz100[3:1];
    assign sec_rank = dmd_pkg::SEC_BASE + (set_khz100[0] ? dmd_pkg::SEC_ODD_HUNDRED : 10'h000)
        + 10'(set_khz10) * dmd_pkg::SEC_TENS_WEIGHT + 10'(set_khz1);

    // one prescaled edge per sys_clk sample; needs input below half sys_clk
    assign step = prescaled_input_signal & ~st_reg.pin_d;
    assign pre_mod = st_reg.mod12 ? dmd_pkg::PRE_MOD_HI : dmd_pkg::PRE_MOD_LO;
    assign pre_done = st_reg.armed && step && (st_reg.pre_cnt >= pre_mod - 4'h1);
    assign ev_out = {st_reg.sec_out, st_reg.div_out};
    // no false edges in the load cycle right after reset
    assign ev_ref = {sec_ref_signal & ~st_reg.ref_d[1], main_ref_signal & ~st_reg.ref_d[0]} & {2{st_reg.armed}};

    dmd_preset_counter #(
        .W(10)
    ) u_sec (
        .clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .step(sec_mixer_signal & ~st_reg.mix_d & st_reg.armed),
        .rank(sec_rank),
        .term(sec_term)
    );

    always_comb begin
        st_next = st_reg;
        st_next.pin_d = prescaled_input_signal;
        st_next.mix_d = sec_mixer_signal;
        st_next.ref_d = {sec_ref_signal, main_ref_signal};
        st_next.div_out = 1'b0;
        st_next.sec_out = sec_term;
        if (!st_reg.armed) begin
            st_next.armed = 1'b1;
            st_next.pre_cnt = 4'h0;
            st_next.rank_left = rank_set;
            st_next.twelve_left = twelve_set;
            st_next.mod12 = (twelve_set != 3'h0);
        end else if (step) begin
            if (pre_done) begin
                st_next.pre_cnt = 4'h0;
                if (st_reg.rank_left <= 5'h01) begin
                    st_next.div_out = 1'b1;
                    st_next.rank_left = rank_set;
                    st_next.twelve_left = twelve_set;
                    st_next.mod12 = (twelve_set != 3'h0);
                end else begin
                    st_next.rank_left = st_reg.rank_left - 5'h01;
                    if (st_reg.twelve_left != 3'h0) begin
                        st_next.twelve_left = st_reg.twelve_left - 3'h1;
                        if (st_reg.twelve_left == 3'h1) begin
                            st_next.mod12 = 1'b0;
                        end
                    end
                end
            end else begin
                st_next.pre_cnt = st_reg.pre_cnt + 4'h1;
            end
        end
        // output pulses counted over a window of reference edges
        for (int i = 0; i < 2; i++) begin
            if (ev_ref[i] && st_reg.win_cnt[i] >= WIN_L - 4'h1) begin
                st_next.win_cnt[i] = 4'h0;
                st_next.hit_cnt[i] = {4'h0, ev_out[i]};
                if (st_reg.hit_cnt[i] + 5'h01 < WIN_W) begin
                    st_next.locked[i] = 1'b0;
                    if (st_reg.code[i] != dmd_pkg::SEARCH_MAX) begin
                        st_next.code[i] = st_reg.code[i] + 8'h01;
                    end
                end else if (st_reg.hit_cnt[i] > WIN_W + 5'h01) begin
                    st_next.locked[i] = 1'b0;
                    if (st_reg.code[i] != dmd_pkg::SEARCH_MIN) begin
                        st_next.code[i] = st_reg.code[i] - 8'h01;
                    end
                end else begin
                    st_next.locked[i] = 1'b1;
                end
            end else begin
                if (ev_ref[i]) begin
                    st_next.win_cnt[i] = st_reg.win_cnt[i] + 4'h1;
                end
                // saturate so a runaway loop cannot wrap the count
                if (ev_out[i] && st_reg.hit_cnt[i] != 5'h1F) begin
                    st_next.hit_cnt[i] = st_reg.hit_cnt[i] + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.code <= {dmd_pkg::SEARCH_MID, dmd_pkg::SEARCH_MID};
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign divided_output_signal = st_reg.div_out;
    assign mod12_sel = st_reg.mod12;
    assign sec_divided_output = st_reg.sec_out;
    assign main_search_code = st_reg.code[0];
    assign sec_search_code = st_reg.code[1];
    assign main_locked = st_reg.locked[0];
    assign sec_locked = st_reg.locked[1];

    // helper: prescaled edges per division while the setting is held
    logic [8:0] edge_cnt;
    logic set_stable;
    logic [4:0] last_rank;
    logic [2:0] last_twelve;
    localparam logic [8:0] RATIO_TEN_WEIGHT_W = dmd_pkg::RATIO_TEN_WEIGHT;
    logic [8:0] exp_ratio;
    assign exp_ratio = 9'(rank_set) * RATIO_TEN_WEIGHT_W + 9'(twelve_set) * dmd_pkg::RATIO_STEP;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt <= 9'h000;
            set_stable <= 1'b0;
            last_rank <= 5'h00;
            last_twelve <= 3'h0;
        end else if (clk_en) begin
            last_rank <= rank_set;
            last_twelve <= twelve_set;
            if (st_reg.div_out) begin
                edge_cnt <= {8'h00, step};
                set_stable <= (rank_set == last_rank) && (twelve_set == last_twelve);
            end else begin
                edge_cnt <= edge_cnt + {8'h00, step && st_reg.armed};
                if (rank_set != last_rank || twelve_set != last_twelve) begin
                    set_stable <= 1'b0;
                end
            end
        end
    end

    property p_start_mod12;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && pre_done && st_reg.rank_left <= 5'h01) |=> (mod12_sel == ($past(twelve_set) != 3'h0));
    endproperty
    a_start_mod12: assert property (p_start_mod12) else $error("mod12 wrong at cycle start");

    property p_mod12_fall;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && $fell(mod12_sel)) |-> $past(pre_done);
    endproperty
    a_mod12_fall: assert property (p_mod12_fall) else $error("mod12 dropped off a cycle end");

    property p_end_on_done;
        @(posedge sys_clk) disable iff (!rst_n)
        divided_output_signal |-> $past(pre_done && st_reg.rank_left <= 5'h01);
    endproperty
    a_end_on_done: assert property (p_end_on_done) else $error("end pulse without last cycle");

    property p_reload;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(divided_output_signal) |-> (st_reg.rank_left == $past(rank_set));
    endproperty
    a_reload: assert property (p_reload) else $error("counter not reloaded");

    property p_ratio;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && st_next.div_out && set_stable && edge_cnt != 9'h000)
            |-> (edge_cnt + 9'h001 == exp_ratio);
    endproperty
    a_ratio: assert property (p_ratio) else $error("division ratio mismatch");

    property p_ratio_range;
        @(posedge sys_clk) disable iff (!rst_n)
        (rank_set >= dmd_pkg::RANK_MIN && rank_set <= dmd_pkg::RANK_MAX && twelve_set < 3'h5)
            |-> (exp_ratio >= dmd_pkg::RATIO_MIN && exp_ratio <= dmd_pkg::RATIO_MAX && !exp_ratio[0]);
    endproperty
    a_ratio_range: assert property (p_ratio_range) else $error("ratio out of range or odd");

    property p_twelve_left;
        @(posedge sys_clk) disable iff (!rst_n)
        (st_reg.armed && mod12_sel) |-> (st_reg.twelve_left != 3'h0);
    endproperty
    a_twelve_left: assert property (p_twelve_left) else $error("mod12 with no twelves left");

    property p_sec_rank;
        @(posedge sys_clk) disable iff (!rst_n)
        (set_khz10 < 4'hA && set_khz1 < 4'hA) |-> (sec_rank >= dmd_pkg::SEC_BASE && sec_rank <= dmd_pkg::SEC_MAX);
    endproperty
    a_sec_rank: assert property (p_sec_rank) else $error("secondary rank out of range");

    property p_search_step;
        @(posedge sys_clk) disable iff (!rst_n)
        (main_search_code != $past(main_search_code)) |-> !main_locked && $past(ev_ref[0]);
    endproperty
    a_search_step: assert property (p_search_step) else $error("search moved while locked");

    property p_sec_search_step;
        @(posedge sys_clk) disable iff (!rst_n)
        (sec_search_code != $past(sec_search_code)) |-> !sec_locked && $past(ev_ref[1]);
    endproperty
    a_sec_search_step: assert property (p_sec_search_step) else $error("sec search moved while locked");

    property p_lock_on_window;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(main_locked) |-> $past(ev_ref[0]);
    endproperty
    a_lock_on_window: assert property (p_lock_on_window) else $error("lock changed off a window end");

    property p_end_one_cycle;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && divided_output_signal) |=> !divided_output_signal;
    endproperty
    a_end_one_cycle: assert property (p_end_one_cycle) else $error("end pulse longer than one cycle");

    property p_sec_one_cycle;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && sec_divided_output) |=> !sec_divided_output;
    endproperty
    a_sec_one_cycle: assert property (p_sec_one_cycle) else $error("sec pulse longer than one cycle");

    property p_mod12_rise;
        @(posedge sys_clk) disable iff (!rst_n)
        (clk_en && $rose(mod12_sel)) |-> $past(!st_reg.armed || (pre_done && st_reg.rank_left <= 5'h01));
    endproperty
    a_mod12_rise: assert property (p_mod12_rise) else $error("mod12 raised inside a cycle");

    c_end: cover property (@(posedge sys_clk) disable iff (!rst_n) divided_output_signal);
    c_all_twelve: cover property (@(posedge sys_clk) disable iff (!rst_n)
        divided_output_signal && twelve_set == 3'h4 && rank_set == dmd_pkg::RANK_MIN);
    c_lock: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(main_locked));
    c_sec: cover property (@(posedge sys_clk) disable iff (!rst_n) sec_divided_output);
endmodule

// File: rtl/dmd_pkg.sv
// How it works
// - input arrives already divided by four
// - end pulses form the 25 kHz output
// - overall ratio even, 40 through 318
// - adjacent ratios differ by exactly two
// - ten/twelve prescaler plus preset cycle counter
// - modulus twelve selected at cycle start
// - switch to ten after twelve-count done
// - ten-cycles equal rank minus twelve-cycles
// - end pulse after last ten-cycle
// - counter reloads, new cycle begins
// - zero twelve-count means ten throughout
// - zero ten-count means twelve throughout
// - secondary rank spans 500 to 699
// - secondary rank follows every setting step
// - discriminator code drives search converter
// - main rank spans 4 to 31
// - search code steps until lock
// - secondary output is 1 kHz when locked
package dmd_pkg;
    localparam logic [4:0] RANK_OFFSET = 5'h02;
    localparam logic [4:0] MHZ_TENS_WEIGHT = 5'h0A;
    localparam logic [4:0] RANK_MIN = 5'h04;
    localparam logic [4:0] RANK_MAX = 5'h1F;
    localparam logic [3:0] PRE_MOD_HI = 4'hC;
    localparam logic [3:0] PRE_MOD_LO = 4'hA;
    localparam logic [8:0] RATIO_TEN_WEIGHT = 9'h00A;
    localparam logic [8:0] RATIO_STEP = 9'h002;
    localparam logic [8:0] RATIO_MIN = 9'h028;
    localparam logic [8:0] RATIO_MAX = 9'h13E;
    localparam logic [9:0] SEC_BASE = 10'h1F4;
    localparam logic [9:0] SEC_MAX = 10'h2BB;
    localparam logic [9:0] SEC_ODD_HUNDRED = 10'h064;
    localparam logic [9:0] SEC_TENS_WEIGHT = 10'h00A;
    localparam logic [7:0] SEARCH_MID = 8'h80;
    localparam logic [7:0] SEARCH_MAX = 8'hFF;
    localparam logic [7:0] SEARCH_MIN = 8'h00;
endpackage

// File: rtl/dmd_preset_counter.sv
`timescale 1ns/1ps
module dmd_preset_counter #(
    parameter int W = 10
) (
    // clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // counting
    input wire logic step,
    input wire logic [W-1:0] rank,
    output logic term
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic term;
    } dmd_cnt_s;

    dmd_cnt_s st_reg;
    dmd_cnt_s st_next;

    if (W < 2) begin : g_bad_width
        $error("dmd_preset_counter: W too small");
    end

    always_comb begin
        st_next = st_reg;
        st_next.term = 1'b0;
        if (step) begin
            // >= guards a rank lowered mid-cycle
            if (st_reg.cnt >= rank - {{(W-1){1'b0}}, 1'b1}) begin
                st_next.cnt = '0;
                st_next.term = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign term = st_reg.term;
endmodule
